// file: timer16.sv
// Purpose: 16-bit timer/counter with AXI4-Lite register access.
// Assumes: aclk at 25 MHz, one instruction cycle is four aclk cycles;
//          pin inputs are synchronous to aclk.
// Notes: Notes on behaviour follow.
// Notes on behaviour
// - Sixteen-bit count in two readable, writable bytes, counts up, wraps.
// - Wrap from all ones to zero sets the sticky overflow flag.
// - Overflow interrupt raised only while the enable bit is set.
// - Control bit 1 picks external pin edges or internal clock.
// - Timer mode counts instruction cycles, counter mode pin rising edges.
// - Control bit 0 runs the counter; cleared, the count holds.
// - Capture/compare unit may clear the count via a reset input.
// - Crystal enabled forces both oscillator pins to inputs.
// - Control bit 3 enables crystal oscillator; cleared shuts it off.
// - With external source, bit 2 set bypasses sync, cleared syncs.
// - With internal source the sync bit is ignored.
// - Sync follows the prescaler; in sleep count stops, prescaler runs.
// - Unsynchronised counter runs in sleep and can raise the interrupt.
// - Counter write coinciding with special event reset: write wins.
// - Count bytes are not cleared by any reset, only the event.
`timescale 1ns/10ps
`include "timer16_defines.svh"

module timer16
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic external_clock_pin,
    output logic external_clock_pin_out,
    output logic external_clock_pin_oe,
    input wire logic crystal_input_pin,
    output logic crystal_input_pin_out,
    output logic crystal_input_pin_oe,
    output logic crystal_amp_enable,
    input wire logic capture_compare_reset,
    input wire logic sleep,
    output logic irq
);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic timer16_pkg::reg_sel_t reg_index(input logic [7:0] a);
        timer16_pkg::reg_sel_t s;
        s = 3'h7;
        case (a)
            `OFS_COUNT_LOW: s = 3'h0;
            `OFS_COUNT_HIGH: s = 3'h1;
            `OFS_FLAG: s = 3'h2;
            `OFS_ENABLE: s = 3'h3;
            `OFS_CONTROL: s = 3'h4;
            `OFS_PIN_CTRL: s = 3'h5;
            default: s = 3'h7;
        endcase
        return s;
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    timer16_pkg::ctrl_t ctrl_r;
    logic [15:0] count_r;
    logic [15:0] count_nxt;
    logic flag_r;
    logic flag_nxt;
    logic mask_r;
    logic [3:0] pin_ctrl_r;
    logic [1:0] div_r;
    logic [2:0] presc_r;
    logic ext_prev_r;
    logic sync1_r;
    logic sync2_r;
    logic [7:0] aw_addr_r;
    logic aw_got_r;
    logic [7:0] w_data_r;
    logic w_lane_r;
    logic w_got_r;

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------
    wire timer16_pkg::reg_sel_t wsel = reg_index(aw_addr_r);
    wire do_write = aw_got_r & w_got_r & ~bvalid;
    wire wr_ok = do_write & (wsel != 3'h7);
    wire wr_en = wr_ok & w_lane_r;
    wire wr_low = wr_en & (wsel == 3'h0);
    wire wr_high = wr_en & (wsel == 3'h1);
    wire wr_flag = wr_en & (wsel == 3'h2);
    wire wr_mask = wr_en & (wsel == 3'h3);
    wire wr_ctrl = wr_en & (wsel == 3'h4);
    wire wr_pin = wr_en & (wsel == 3'h5);
    wire wr_count = wr_low | wr_high;

    // ------------------------------------------------------------------
    // Clock source, prescaler and synchroniser
    // ------------------------------------------------------------------
    // The crystal drives the count pin when its oscillator is enabled.
    wire ext_level = ctrl_r.crystal_osc_enable ? crystal_input_pin
                                               : external_clock_pin;
    wire ext_rise = ext_level & ~ext_prev_r;
    // The instruction clock is stopped while the core sleeps.
    wire inst_tick = (div_r == `INST_DIV_LAST) & ~sleep;
    wire src_tick = ctrl_r.clock_source_select ? ext_rise
                                               : inst_tick;
    wire [2:0] presc_mask = 3'((4'h1 << ctrl_r.prescale_select) - 4'h1);
    wire presc_tick = src_tick & ctrl_r.counter_on
                    & ((presc_r & presc_mask) == presc_mask);
    // Internal source ignores the bypass bit and never waits on sync.
    wire use_sync = ctrl_r.clock_source_select
                  & ~ctrl_r.sync_bypass;
    wire advance = ctrl_r.counter_on
                 & (use_sync ? (sync2_r & ~sleep) : presc_tick);
    wire wrap = advance & (count_r == `COUNT_ALL_ONES);

    // ------------------------------------------------------------------
    // Count and flag next values
    // ------------------------------------------------------------------
    always_comb
    begin
        count_nxt = count_r;
        if (wr_low)
        begin
            count_nxt = {count_r[15:8], w_data_r};
        end
        else if (wr_high)
        begin
            count_nxt = {w_data_r, count_r[7:0]};
        end
        else if (capture_compare_reset)
        begin
            count_nxt = 16'h0000;
        end
        else if (advance)
        begin
            count_nxt = count_r + 16'h0001;
        end
    end

    // A write or a special event pre-empts the step, so no wrap is seen.
    wire overflow_set = wrap & ~wr_count & ~capture_compare_reset;
    // Set wins over a simultaneous write-one-to-clear.
    assign flag_nxt = overflow_set
                    | (flag_r & ~(wr_flag & w_data_r[`OVERFLOW_BIT]));

    // ------------------------------------------------------------------
    // Counter datapath
    // ------------------------------------------------------------------
    // The count bytes deliberately have no reset.
    always_ff @(posedge aclk)
    begin
        count_r <= count_nxt;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            div_r <= 2'h0;
            presc_r <= 3'h0;
            ext_prev_r <= 1'b0;
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            flag_r <= 1'b0;
        end
        else
        begin
            div_r <= div_r + 2'h1;
            ext_prev_r <= ext_level;
            if (wr_count)
            begin
                presc_r <= 3'h0;
            end
            else if (src_tick & ctrl_r.counter_on)
            begin
                presc_r <= presc_r + 3'h1;
            end
            sync1_r <= presc_tick & use_sync;
            sync2_r <= sync1_r;
            flag_r <= flag_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Software registers and pins
    // ------------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_r <= `CONTROL_RESET;
            mask_r <= 1'b0;
            pin_ctrl_r <= `PIN_CTRL_RESET;
            irq <= 1'b0;
            crystal_amp_enable <= 1'b0;
            external_clock_pin_oe <= 1'b0;
            crystal_input_pin_oe <= 1'b0;
            external_clock_pin_out <= 1'b0;
            crystal_input_pin_out <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                ctrl_r <= {2'h0, w_data_r[5:0]};
            end
            if (wr_mask)
            begin
                mask_r <= w_data_r[`OVERFLOW_BIT];
            end
            if (wr_pin)
            begin
                pin_ctrl_r <= w_data_r[3:0];
            end
            irq <= flag_nxt & mask_r;
            crystal_amp_enable <= ctrl_r.crystal_osc_enable;
            // Direction bit 1 means input; the oscillator overrides both.
            external_clock_pin_oe <= ~ctrl_r.crystal_osc_enable
                                   & ~pin_ctrl_r[`PIN_DIR_LSB];
            crystal_input_pin_oe <= ~ctrl_r.crystal_osc_enable
                                  & ~pin_ctrl_r[`PIN_DIR_LSB + 1];
            external_clock_pin_out <= pin_ctrl_r[`PIN_DATA_LSB];
            crystal_input_pin_out <= pin_ctrl_r[`PIN_DATA_LSB + 1];
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 8'h00;
            w_lane_r <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `AXI_OKAY;
        end
        else
        begin
            if (awvalid & awready)
            begin
                aw_addr_r <= awaddr;
                aw_got_r <= 1'b1;
                awready <= 1'b0;
            end
            if (wvalid & wready)
            begin
                w_data_r <= wdata[7:0];
                w_lane_r <= wstrb[0];
                w_got_r <= 1'b1;
                wready <= 1'b0;
            end
            if (do_write)
            begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                bvalid <= 1'b1;
                bresp <= (wsel == 3'h7) ? `AXI_SLVERR : `AXI_OKAY;
            end
            if (bvalid & bready)
            begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------
    wire timer16_pkg::reg_sel_t rsel = reg_index(araddr);
    logic [7:0] rbyte;
    always_comb
    begin
        case (rsel)
            3'h0: rbyte = count_r[7:0];
            3'h1: rbyte = count_r[15:8];
            3'h2: rbyte = {7'h00, flag_r};
            3'h3: rbyte = {7'h00, mask_r};
            3'h4: rbyte = ctrl_r;
            3'h5: rbyte = {4'h0, pin_ctrl_r};
            default: rbyte = 8'h00;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `AXI_OKAY;
        end
        else if (arvalid & arready)
        begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= {24'h000000, rbyte};
            rresp <= (rsel == 3'h7) ? `AXI_SLVERR : `AXI_OKAY;
        end
        else if (rvalid & rready)
        begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_count_wrap: assert property (overflow_set |=> count_r == 16'h0000 && flag_r)
        else $error("count did not wrap to zero with flag set");
    a_flag_sticky: assert property (flag_r && !wr_flag |=> flag_r)
        else $error("overflow flag dropped without a clear");
    a_irq_masked: assert property (##1 irq == ($past(mask_r) && flag_r))
        else $error("interrupt output does not follow flag and mask");
    a_timer_pace: assert property (!ctrl_r.clock_source_select && advance |-> $past(div_r, 1) == 2'h2)
        else $error("timer mode step off the instruction cycle");
    a_off_holds: assert property (!ctrl_r.counter_on && !wr_count && !capture_compare_reset |=> $stable(count_r))
        else $error("stopped counter changed");
    a_event_clear: assert property (capture_compare_reset && !wr_count |=> count_r == 16'h0000)
        else $error("special event did not clear the count");
    a_osc_pins_in: assert property (ctrl_r.crystal_osc_enable [*2] |-> !external_clock_pin_oe && !crystal_input_pin_oe)
        else $error("oscillator pins driven while crystal enabled");
    a_osc_amp: assert property (##1 crystal_amp_enable == $past(ctrl_r.crystal_osc_enable))
        else $error("oscillator amplifier enable wrong");
    a_presc_ratio: assert property (presc_tick && !wr_count && !wr_ctrl |=> (presc_r & presc_mask) == 3'h0)
        else $error("prescaler output off ratio");
    a_presc_clear: assert property (wr_count |=> presc_r == 3'h0)
        else $error("prescaler not cleared by counter write");
    a_sync_path: assert property (use_sync && ctrl_r.counter_on && !sleep && presc_tick |-> ##2 advance || $past(ctrl_r, 1) != ctrl_r || sleep)
        else $error("synchronised step not two cycles after prescaler");
    a_sync_sleep: assert property (use_sync && sleep |-> !advance)
        else $error("synchronised counter advanced in sleep");
    a_async_runs: assert property (ctrl_r.clock_source_select && ctrl_r.sync_bypass && sleep && presc_tick && !wr_count && !capture_compare_reset |=> count_r == $past(count_r) + 16'h0001)
        else $error("unsynchronised counter missed a step");
    a_write_wins: assert property (wr_low && capture_compare_reset |=> count_r[7:0] == $past(w_data_r))
        else $error("special event beat a counter write");

endmodule

// file: timer16_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: Included by the timer16 design and test bench files.
// Notes: Register offsets are byte addresses of aligned 32-bit words.
`ifndef TIMER16_DEFINES_SVH
`define TIMER16_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_COUNT_LOW 8'h00
`define OFS_COUNT_HIGH 8'h04
`define OFS_FLAG 8'h08
`define OFS_ENABLE 8'h0c
`define OFS_CONTROL 8'h10
`define OFS_PIN_CTRL 8'h14

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define OVERFLOW_BIT 0
`define PIN_DIR_LSB 0
`define PIN_DATA_LSB 2
`define CONTROL_RESET 8'h00
`define PIN_CTRL_RESET 4'hf
`define COUNT_ALL_ONES 16'hffff

// ----------------------------------------------------------------------
// Timing and AXI response codes
// ----------------------------------------------------------------------
`define FOSC_MHZ 100
`define CLK_MHZ 25
`define INST_DIV_LAST 2'h3
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2

`endif

// file: timer16_pkg.sv
// Purpose: Types shared by the 16-bit timer/counter.
// Assumes: Field layout follows timer16_defines.svh.
// Notes: Nothing here is imported; users write timer16_pkg::name.
package timer16_pkg;

    // Control register layout, bit 7 down to bit 0.
    typedef struct packed {
        logic [1:0] unused;
        logic [1:0] prescale_select;
        logic crystal_osc_enable;
        logic sync_bypass;
        logic clock_source_select;
        logic counter_on;
    } ctrl_t;

    typedef logic [2:0] reg_sel_t;

endpackage

// file: ext_clock_source.sv
// Purpose: Behavioural external clock source for the counter pins.
// Assumes: One aclk domain; run is driven by the bench.
// Notes: The clock stands low outside a run, with period 8 aclk inside.
`timescale 1ns/10ps

module ext_clock_source
(
    input wire logic aclk,
    input wire logic run,
    output logic clk_pin
);
    logic [1:0] phase_r;

    // A stopped source holds its line low so no stray edge is seen.
    always @(posedge aclk)
    begin
        if (!run)
        begin
            phase_r <= 2'h0;
            clk_pin <= 1'b0;
        end
        else
        begin
            phase_r <= phase_r + 2'h1;
            if (phase_r == 2'h3)
                clk_pin <= !clk_pin;
        end
    end

endmodule

// file: test_timer16.sv
// Purpose: Self-checking bench for the 16-bit timer/counter.
// Assumes: AXI4-Lite register access, 40 ns aclk.
// Notes: Timer-mode counts are checked within a small tolerance, pin counts exactly.
`timescale 1ns/10ps
`include "timer16_defines.svh"

module test_timer16;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, irq, amp;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, v;
    logic ext_out, ext_oe, xt_out, xt_oe, ext_w, xt_w, src, src_q;
    logic run = 1'b0, to_xtal = 1'b0, ccr = 1'b0, slp = 1'b0;
    logic [1:0] resp;
    int err_count = 0, samples_checked = 0, edges = 0, e0, k;
    logic [7:0] mode [5] = '{8'h07, 8'h03, 8'h03, 8'h07, 8'h0f};
    logic slp_tab [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

    // The pin level is the design's own drive while enabled.
    assign ext_w = ext_oe ? ext_out : (to_xtal ? 1'b0 : src);
    assign xt_w = xt_oe ? xt_out : (to_xtal ? src : 1'b0);

    initial forever #20 aclk = !aclk;

    always @(posedge aclk)
    begin
        src_q <= src;
        if (src && !src_q)
            edges <= edges + 1;
    end

    ext_clock_source partner (.aclk(aclk), .run(run), .clk_pin(src));

    timer16 DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .external_clock_pin(ext_w), .external_clock_pin_out(ext_out),
        .external_clock_pin_oe(ext_oe), .crystal_input_pin(xt_w),
        .crystal_input_pin_out(xt_out), .crystal_input_pin_oe(xt_oe),
        .crystal_amp_enable(amp), .capture_compare_reset(ccr),
        .sleep(slp), .irq(irq));

    task automatic tally_and_finish();
        if (err_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            $display("unexpected at %0t: seen %h expected %h",
                $time, seen, exp);
            err_count++;
        end
    endtask

    task automatic limit(input int n);
        if (n > 100)
        begin
            err_count++;
            tally_and_finish();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= 4'h1;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            limit(n);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
        end
        while (!(bvalid && bready));
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            limit(n);
            if (arvalid && arready)
                arvalid <= 1'b0;
        end
        while (!(rvalid && rready));
        v = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic set_count(input logic [7:0] hi, input logic [7:0] lo);
        wr(`OFS_COUNT_HIGH, hi);
        wr(`OFS_COUNT_LOW, lo);
    endtask

    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        // ------------------------------------------------------------
        // Reset values, unmapped access and read-as-zero bits
        // ------------------------------------------------------------
        rd(`OFS_CONTROL);
        check(v, 32'h00);
        rd(`OFS_ENABLE);
        check(v, 32'h00);
        rd(`OFS_FLAG);
        check(v, 32'h00);
        rd(8'h18);
        check({30'h0, resp}, {30'h0, `AXI_SLVERR});
        wr(8'h18, 8'h55);
        check({30'h0, resp}, {30'h0, `AXI_SLVERR});
        wr(`OFS_CONTROL, 8'hfe);
        check({30'h0, resp}, {30'h0, `AXI_OKAY});
        rd(`OFS_CONTROL);
        check(v, 32'h3e);
        set_count(8'ha5, 8'h3c);
        wr(`OFS_CONTROL, 8'h00);
        rd(`OFS_COUNT_HIGH);
        check(v, 32'ha5);
        rd(`OFS_COUNT_LOW);
        check(v, 32'h3c);
        // ------------------------------------------------------------
        // Timer mode rate per prescale code; sync bit has no effect
        // ------------------------------------------------------------
        for (k = 0; k < 4; k++)
        begin
            set_count(8'h00, 8'h00);
            wr(`OFS_CONTROL, {2'b00, k[1:0], 1'b0, k[0], 2'b01});
            repeat (400) @(posedge aclk);
            wr(`OFS_CONTROL, 8'h00);
            rd(`OFS_COUNT_LOW);
            e0 = 100 >> k;
            check(v >= e0 - 2 && v <= e0 + 2, 1);
        end
        repeat (40) @(posedge aclk);
        e0 = v;
        rd(`OFS_COUNT_LOW);
        check(v, e0);
        // ------------------------------------------------------------
        // Overflow flag, mask and write-one-to-clear
        // ------------------------------------------------------------
        set_count(8'hff, 8'hfe);
        wr(`OFS_CONTROL, 8'h01);
        repeat (40) @(posedge aclk);
        wr(`OFS_CONTROL, 8'h00);
        rd(`OFS_COUNT_HIGH);
        check(v, 32'h00);
        rd(`OFS_FLAG);
        check(v, 32'h01);
        check(irq, 1'b0);
        wr(`OFS_ENABLE, 8'h01);
        repeat (2) @(posedge aclk);
        check(irq, 1'b1);
        wr(`OFS_FLAG, 8'h00);
        rd(`OFS_FLAG);
        check(v, 32'h01);
        wr(`OFS_FLAG, 8'h01);
        repeat (2) @(posedge aclk);
        check(irq, 1'b0);
        // ------------------------------------------------------------
        // Counter modes, sleep and crystal pin source
        // ------------------------------------------------------------
        for (k = 0; k < 5; k++)
        begin
            set_count(8'h00, 8'h00);
            to_xtal <= mode[k][3];
            slp <= slp_tab[k];
            wr(`OFS_CONTROL, mode[k]);
            e0 = edges;
            run <= 1'b1;
            repeat (80) @(posedge aclk);
            run <= 1'b0;
            repeat (10) @(posedge aclk);
            e0 = (slp && !mode[k][2]) ? 0 : edges - e0;
            slp <= 1'b0;
            rd(`OFS_COUNT_LOW);
            check(v, e0);
        end
        // ------------------------------------------------------------
        // Pin direction override and oscillator enable
        // ------------------------------------------------------------
        wr(`OFS_CONTROL, 8'h00);
        wr(`OFS_PIN_CTRL, 8'h08);
        repeat (2) @(posedge aclk);
        check({amp, ext_oe, xt_oe, ext_out, xt_out}, 5'h0d);
        wr(`OFS_CONTROL, 8'h08);
        repeat (2) @(posedge aclk);
        check({amp, ext_oe, xt_oe}, 3'h4);
        wr(`OFS_CONTROL, 8'h00);
        wr(`OFS_PIN_CTRL, `PIN_CTRL_RESET);
        // ------------------------------------------------------------
        // Special event clear and count kept over reset
        // ------------------------------------------------------------
        set_count(8'h12, 8'h34);
        @(posedge aclk);
        ccr <= 1'b1;
        @(posedge aclk);
        ccr <= 1'b0;
        rd(`OFS_COUNT_HIGH);
        check(v, 32'h00);
        rd(`OFS_FLAG);
        check(v, 32'h00);
        // A special event in the very cycle of a low-byte write.
        fork
            wr(`OFS_COUNT_LOW, 8'h77);
            begin
                repeat (2) @(posedge aclk);
                ccr <= 1'b1;
                @(posedge aclk);
                ccr <= 1'b0;
            end
        join
        rd(`OFS_COUNT_LOW);
        check(v, 32'h77);
        set_count(8'h5a, 8'hc3);
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`OFS_COUNT_LOW);
        check(v, 32'hc3);
        rd(`OFS_COUNT_HIGH);
        check(v, 32'h5a);
        tally_and_finish();
    end
endmodule
